// >>> design/mao_port.sv
/*
  Top of the mirror array output port: DDR bit-plane lanes with their
  forwarded clock and strobes, the serial driver bus and the I2C register.
  Assumes bit-plane words and requests come from logic on CLK; the I2C
  pins come from outside and are synchronised inside the register block.
*/
`timescale 1ns/10ps
`default_nettype none
module mao_port #(
  parameter logic [6:0] I2C_ADDR = 7'h1B // arbitrary target address
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // bit-plane word stream
  input wire logic [14:0] PLANE_WORD,
  input wire logic PLANE_LOAD,
  input wire logic PLANE_SCTRL,
  input wire logic PLANE_TRC,
  input wire logic PLANE_VALID,
  output logic PLANE_READY,
  // array format
  input wire mao_pkg::mao_fmt_type ARRAY_FMT,
  // array data pins
  output logic [14:0] PLANE_DATA_LANE,
  output logic PLANE_DATA_CLOCK,
  output logic PLANE_LOAD_N,
  output logic PLANE_SERIAL_CTRL,
  output logic TOGGLE_RATE_CTRL,
  // reset driver enable
  input wire logic DRV_ENABLE,
  output logic RESET_DRIVER_OUT_EN_N,
  // serial bus words
  input wire logic SER_VALID,
  output logic SER_READY,
  input wire logic [15:0] SER_DRV_WORD,
  input wire logic [15:0] SER_ARRAY_WORD,
  // serial bus pins
  output logic RESET_DRIVER_BUS_DATA,
  output logic RESET_DRIVER_BUS_STROBE,
  output logic ARRAY_CTRL_BUS_DATA,
  output logic ARRAY_CTRL_BUS_CLOCK,
  // I2C control pins
  input wire logic I2C_SCL,
  input wire logic I2C_SDA_IN,
  output logic I2C_SDA_OUT,
  output logic I2C_SDA_OE,
  // status
  output logic BUS_SWAP
);
  import mao_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic dclk;
    logic [14:0] lane;
    logic load_n;
    logic sctrl;
    logic trc;
    logic oe_n;
  } mao_ddr_type;

  // lanes parked low, strobe idle high, mirror driver disabled
  localparam mao_ddr_type D_RST = '{CNT_ZERO, 1'b0, LANE_ZERO, 1'b1, 1'b0, 1'b0, 1'b1};

  mao_ddr_type s_r, s_nxt;
  logic swap;
  logic launch;
  logic accepted;
  logic [14:0] masked;
  logic [14:0] flipped;
  logic [14:0] lane_map;

  // bit order register behind the I2C pins
  mao_i2c_reg #(
    .DEV_ADDR(I2C_ADDR)
  ) u_i2c (
    .clk(CLK),
    .reset(RESET),
    .scl_in(I2C_SCL),
    .sda_in(I2C_SDA_IN),
    .sda_out(I2C_SDA_OUT),
    .sda_oe(I2C_SDA_OE),
    .swap(swap)
  );

  // reset driver and array control serial bus
  mao_ser_bus u_ser (
    .clk(CLK),
    .reset(RESET),
    .valid(SER_VALID),
    .ready(SER_READY),
    .drv_word(SER_DRV_WORD),
    .arr_word(SER_ARRAY_WORD),
    .drv_data(RESET_DRIVER_BUS_DATA),
    .drv_strobe(RESET_DRIVER_BUS_STROBE),
    .arr_data(ARRAY_CTRL_BUS_DATA),
    .sclk(ARRAY_CTRL_BUS_CLOCK)
  );

  // small format keeps only its low twelve bits, the top three stay zero
  assign masked = (ARRAY_FMT == FMT_NHD) ? (PLANE_WORD & NHD_MASK) : PLANE_WORD;

  // lane reversal, one wire per lane
  for (genvar i = 0; i < LANES; i++) begin : g_flip
    assign flipped[i] = masked[LANES - 1 - i];
  end

  // normal order keeps the word on the low lanes
  assign lane_map = swap ? flipped : masked;

  // a word is taken once per half period of the data clock
  assign launch = (s_r.cnt == CNT_ZERO);
  assign accepted = launch & PLANE_VALID;
  assign PLANE_READY = launch & ~RESET;

  // divider, lane launch and strobes
  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt == DCLK_LAST) begin
      s_nxt.cnt = CNT_ZERO;
      s_nxt.dclk = ~s_r.dclk; // edges fall mid-word
    end else begin
      s_nxt.cnt = s_r.cnt + 4'h1;
    end
    if (launch) begin
      if (PLANE_VALID) begin
        s_nxt.lane = lane_map; // new word every half period
        s_nxt.load_n = ~PLANE_LOAD;
        s_nxt.sctrl = PLANE_SCTRL;
        s_nxt.trc = PLANE_TRC;
      end else begin
        s_nxt.load_n = 1'b1; // no load without a word
        s_nxt.sctrl = 1'b0;
        s_nxt.trc = 1'b0;
      end
    end
    s_nxt.oe_n = ~DRV_ENABLE; // follows request, not any link clock
  end

  // state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_r <= D_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // pins straight from flip-flops
  assign PLANE_DATA_LANE = s_r.lane;
  assign PLANE_DATA_CLOCK = s_r.dclk;
  assign PLANE_LOAD_N = s_r.load_n;
  assign PLANE_SERIAL_CTRL = s_r.sctrl;
  assign TOGGLE_RATE_CTRL = s_r.trc;
  assign RESET_DRIVER_OUT_EN_N = s_r.oe_n;
  assign BUS_SWAP = swap;

  // checks on the array side of the port
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // a taken word lands on the lanes, then the clock edge arrives
  property p_ddr_launch;
    accepted |=> $stable(PLANE_DATA_CLOCK) ##1 $changed(PLANE_DATA_CLOCK);
  endproperty
  a_ddr_launch: assert property (p_ddr_launch)
    else $error("data clock edge not centred on a lane word");

  // the forwarded clock toggles every second cycle
  property p_dclk_rate;
    $changed(PLANE_DATA_CLOCK) |=> $stable(PLANE_DATA_CLOCK) ##1 $changed(PLANE_DATA_CLOCK);
  endproperty
  a_dclk_rate: assert property (p_dclk_rate)
    else $error("data clock period wrong");

  property p_full_lanes;
    accepted && ARRAY_FMT == FMT_FULL && !swap |=> PLANE_DATA_LANE == $past(PLANE_WORD);
  endproperty
  a_full_lanes: assert property (p_full_lanes)
    else $error("wide format lost a lane");

  property p_nhd_unused;
    accepted && ARRAY_FMT == FMT_NHD |=>
      ($past(swap) ? PLANE_DATA_LANE[2:0] : PLANE_DATA_LANE[14:12]) == 3'h0;
  endproperty
  a_nhd_unused: assert property (p_nhd_unused)
    else $error("unused lanes driven in small format");

  property p_nhd_low;
    accepted && ARRAY_FMT == FMT_NHD && !swap |=>
      PLANE_DATA_LANE[11:0] == $past(PLANE_WORD[11:0]);
  endproperty
  a_nhd_low: assert property (p_nhd_low)
    else $error("small format not on low lanes");

  property p_nhd_swap;
    accepted && ARRAY_FMT == FMT_NHD && swap |=>
      PLANE_DATA_LANE[14] == $past(PLANE_WORD[0]) && PLANE_DATA_LANE[3] == $past(PLANE_WORD[11]);
  endproperty
  a_nhd_swap: assert property (p_nhd_swap)
    else $error("reversed order not on lanes 14 to 3");

  property p_load_strobe;
    accepted && PLANE_LOAD |=> !PLANE_LOAD_N [*2];
  endproperty
  a_load_strobe: assert property (p_load_strobe)
    else $error("load strobe not held for the word");

  property p_sctrl_edge;
    $changed(PLANE_SERIAL_CTRL) |-> $past(launch);
  endproperty
  a_sctrl_edge: assert property (p_sctrl_edge)
    else $error("serial control moved off a launch");

  property p_trc_follow;
    accepted |=> TOGGLE_RATE_CTRL == $past(PLANE_TRC) ##1 $stable(TOGGLE_RATE_CTRL);
  endproperty
  a_trc_follow: assert property (p_trc_follow)
    else $error("toggle rate control not launched with the word");

  property p_oe_follow;
    DRV_ENABLE ##1 DRV_ENABLE |-> !RESET_DRIVER_OUT_EN_N;
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("driver enable not active low");

  property p_oe_park;
    !DRV_ENABLE |=> RESET_DRIVER_OUT_EN_N;
  endproperty
  a_oe_park: assert property (p_oe_park)
    else $error("driver enabled without request");

  // one word slot in every two cycles
  property p_ready_slot;
    PLANE_READY |=> !PLANE_READY;
  endproperty
  a_ready_slot: assert property (p_ready_slot)
    else $error("word slot offered twice in a row");

  // lanes only move when a word is taken
  property p_lane_hold;
    !accepted |=> $stable(PLANE_DATA_LANE);
  endproperty
  a_lane_hold: assert property (p_lane_hold)
    else $error("lanes moved without a word");

  // wide format reversed end to end
  property p_full_swap;
    accepted && ARRAY_FMT == FMT_FULL && swap |=>
      PLANE_DATA_LANE[14] == $past(PLANE_WORD[0]) && PLANE_DATA_LANE[0] == $past(PLANE_WORD[14]);
  endproperty
  a_full_swap: assert property (p_full_swap)
    else $error("wide format not reversed");

  // an empty slot leaves the load strobe idle
  property p_load_idle;
    launch && !PLANE_VALID |=> PLANE_LOAD_N;
  endproperty
  a_load_idle: assert property (p_load_idle)
    else $error("load strobe without a word");

  // serial control launched with its word
  property p_sctrl_follow;
    accepted |=> PLANE_SERIAL_CTRL == $past(PLANE_SCTRL);
  endproperty
  a_sctrl_follow: assert property (p_sctrl_follow)
    else $error("serial control not launched with the word");

  // an empty slot parks serial and toggle rate control low
  property p_ctrl_idle;
    launch && !PLANE_VALID |=> !PLANE_SERIAL_CTRL && !TOGGLE_RATE_CTRL;
  endproperty
  a_ctrl_idle: assert property (p_ctrl_idle)
    else $error("control lines active in an empty slot");

  // driver enable only moves to follow the request
  property p_oe_only;
    $changed(RESET_DRIVER_OUT_EN_N) |-> RESET_DRIVER_OUT_EN_N == !$past(DRV_ENABLE);
  endproperty
  a_oe_only: assert property (p_oe_only)
    else $error("driver enable moved on its own");

  // the forwarded clock holds still across a launch
  property p_dclk_quiet;
    launch |=> $stable(PLANE_DATA_CLOCK);
  endproperty
  a_dclk_quiet: assert property (p_dclk_quiet)
    else $error("data clock moved with the lanes");

  // serial word slot is a one-cycle pulse
  property p_ser_ready;
    SER_READY |=> !SER_READY;
  endproperty
  a_ser_ready: assert property (p_ser_ready)
    else $error("serial word slot longer than a cycle");

  // serial clock toggles every second cycle
  property p_ser_clk_rate;
    $changed(ARRAY_CTRL_BUS_CLOCK) |=>
      $stable(ARRAY_CTRL_BUS_CLOCK) ##1 $changed(ARRAY_CTRL_BUS_CLOCK);
  endproperty
  a_ser_clk_rate: assert property (p_ser_clk_rate)
    else $error("serial clock period wrong");

  // main scenarios
  c_full_word: cover property (accepted && ARRAY_FMT == FMT_FULL && PLANE_LOAD);
  c_nhd_swap: cover property (accepted && ARRAY_FMT == FMT_NHD && swap);
  c_back_to_back: cover property (accepted ##2 accepted ##2 accepted);
  c_drv_on: cover property ($fell(RESET_DRIVER_OUT_EN_N));
endmodule
`default_nettype wire

// >>> design/mao_pkg.sv
/*
  Constants, types and timing for the mirror array output port.
  Assumes a single 20 MHz system clock; all slower rates come from dividers.
*/
// What this block does
// - Bit-plane lanes get a new value on every rising and every falling edge of the data clock.
// - The wide array formats use all 15 data lanes for bit-plane words.
// - The small array format uses 12 lanes and leaves the other three at zero.
// - With normal bit order the small format sits on lanes 11 down to 0.
// - When the bit order register at 0xA7 selects reversal the lane order flips.
// - An active-low load strobe goes out timed with the data clock.
// - A serial control signal goes out timed with the data clock.
// - A toggle rate control signal goes out timed with the data clock.
// - The reset driver output enable is active low and tied to no interface clock.
// - The block makes the forwarded data clock itself from its own divider.
package mao_pkg;
  // lane layout
  localparam int LANES = 15;
  localparam int NHD_LANES = 12;
  localparam logic [14:0] NHD_MASK = 15'h0FFF;
  localparam logic [14:0] LANE_ZERO = 15'h0000;
  // bit order register
  localparam logic [7:0] REG_BUS_SWAP = 8'hA7;
  localparam int SWAP_BIT = 0;
  localparam logic SWAP_RST = 1'b0;
  localparam logic [7:0] REG_RD_ZERO = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DCLK_HALF_NS = 100;
  localparam int DCLK_HALF_CYC = (DCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DCLK_LAST = 4'(DCLK_HALF_CYC - 1);
  localparam int SER_HALF_NS = 100;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SER_CYC_LAST = 4'(SER_HALF_CYC - 1);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  // serial bus word
  localparam int SER_BITS = 16;
  localparam logic [4:0] SER_LAST = 5'(SER_BITS - 1);
  localparam logic [4:0] SER_PRE_LAST = 5'(SER_BITS - 2);
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  // array formats
  typedef enum logic {FMT_FULL = 1'b0, FMT_NHD = 1'b1} mao_fmt_type;
  // control port states, gray along idle-recv-ack-send-rack
  typedef enum logic [2:0] {
    I2C_IDLE = 3'h0,
    I2C_RECV = 3'h1,
    I2C_ACK = 3'h3,
    I2C_SEND = 3'h2,
    I2C_RACK = 3'h6
  } mao_i2c_state_type;
endpackage

// >>> design/mao_i2c_reg.sv
/*
  I2C target holding the bus bit order register.
  Assumes raw SCL and SDA pins from outside; both pass two flip-flops first.
*/
`timescale 1ns/10ps
`default_nettype none
module mao_i2c_reg #(
  parameter logic [6:0] DEV_ADDR = 7'h1B
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // register value
  output logic swap
);
  import mao_pkg::*;
  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    mao_i2c_state_type st;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic [1:0] byten;
    logic rd, hit, drive, swap;
  } mao_i2c_type;
  localparam mao_i2c_type I_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, I2C_IDLE,
    8'h00, 4'h0, 2'h0, 1'b0, 1'b0, 1'b0, SWAP_RST};
  mao_i2c_type s_r, s_nxt;
  logic rise, fall, start, stop;
  logic [7:0] rdata;
  // bus events from the second and third sampling stages
  assign rise = s_r.scl2 & ~s_r.scl3;
  assign fall = ~s_r.scl2 & s_r.scl3;
  assign start = s_r.scl2 & s_r.scl3 & s_r.sda3 & ~s_r.sda2;
  assign stop = s_r.scl2 & s_r.scl3 & ~s_r.sda3 & s_r.sda2;
  // next state of the target
  always_comb begin
    rdata = REG_RD_ZERO;
    rdata[SWAP_BIT] = s_r.hit & s_r.swap; // reserved bits read zero
    s_nxt = s_r;
    s_nxt.scl1 = scl_in;
    s_nxt.scl2 = s_r.scl1;
    s_nxt.scl3 = s_r.scl2;
    s_nxt.sda1 = sda_in;
    s_nxt.sda2 = s_r.sda1;
    s_nxt.sda3 = s_r.sda2;
    if (start) begin
      s_nxt.st = I2C_RECV;
      s_nxt.bitc = 4'h0;
      s_nxt.byten = 2'h0;
      s_nxt.drive = 1'b0;
    end else if (stop) begin
      s_nxt.st = I2C_IDLE;
      s_nxt.drive = 1'b0;
    end else begin
      case (s_r.st)
        I2C_IDLE: s_nxt.drive = 1'b0;
        I2C_RECV: begin
          if (rise) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda2};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (fall && s_r.bitc == I2C_BYTE_BITS) begin
            s_nxt.bitc = 4'h0;
            s_nxt.st = I2C_ACK;
            s_nxt.drive = 1'b1;
            case (s_r.byten)
              2'h0: begin
                s_nxt.rd = s_r.sh[0];
                if (s_r.sh[7:1] != DEV_ADDR) begin
                  s_nxt.st = I2C_IDLE;
                  s_nxt.drive = 1'b0;
                end
              end
              2'h1: s_nxt.hit = (s_r.sh == REG_BUS_SWAP);
              default: if (s_r.hit) s_nxt.swap = s_r.sh[SWAP_BIT];
            endcase
          end
        end
        I2C_ACK: if (fall) begin
          s_nxt.drive = 1'b0;
          s_nxt.st = I2C_RECV;
          if (s_r.rd && s_r.byten == 2'h0) begin
            s_nxt.st = I2C_SEND;
            s_nxt.sh = rdata;
            s_nxt.drive = ~rdata[7];
            s_nxt.bitc = 4'h0;
          end else if (s_r.byten != 2'h2) begin
            s_nxt.byten = s_r.byten + 2'h1;
          end
        end
        I2C_SEND: begin
          if (rise) begin
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (fall) begin
            if (s_r.bitc == I2C_BYTE_BITS) begin
              s_nxt.st = I2C_RACK;
              s_nxt.drive = 1'b0;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.drive = ~s_r.sh[6];
            end
          end
        end
        I2C_RACK: begin
          if (rise && s_r.sda2) begin
            s_nxt.st = I2C_IDLE; // master ended the read
          end else if (fall) begin
            s_nxt.st = I2C_SEND;
            s_nxt.sh = rdata;
            s_nxt.drive = ~rdata[7];
            s_nxt.bitc = 4'h0;
          end
        end
        default: s_nxt.st = I2C_IDLE;
      endcase
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (reset) s_r <= I_RST;
    else s_r <= s_nxt;
  end
  assign sda_out = 1'b0;
  assign sda_oe = s_r.drive;
  assign swap = s_r.swap;
  // register only changes after the data byte of a write
  property p_swap_write;
    @(posedge clk) disable iff (reset)
      $changed(s_r.swap) |-> $past(s_r.st) == I2C_RECV && $past(s_r.byten) == 2'h2;
  endproperty
  a_swap_write: assert property (p_swap_write)
    else $error("bit order changed outside a data byte");
endmodule
`default_nettype wire

// >>> design/mao_ser_bus.sv
/*
  Serial bus for the reset driver and array control words.
  Assumes words arrive from logic on the same clock with a valid and ready pair.
*/
`timescale 1ns/10ps
`default_nettype none
module mao_ser_bus (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // word request
  input wire logic valid,
  output logic ready,
  input wire logic [15:0] drv_word,
  input wire logic [15:0] arr_word,
  // pins
  output logic drv_data,
  output logic drv_strobe,
  output logic arr_data,
  output logic sclk
);
  import mao_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic sclk, busy, strobe;
    logic [4:0] bitc;
    logic [15:0] sh_d, sh_a;
  } mao_ser_type;
  localparam mao_ser_type R_RST = '{CNT_ZERO, 1'b0, 1'b0, 1'b0, 5'h00, 16'h0000, 16'h0000};
  mao_ser_type s_r, s_nxt;
  logic tick, falling, more;
  assign tick = (s_r.cnt == SER_CYC_LAST);
  assign falling = tick & s_r.sclk;
  assign more = s_r.busy && (s_r.bitc != SER_LAST);
  assign ready = falling & ~more;
  // free running clock, bits change on its falling edge
  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = tick ? CNT_ZERO : s_r.cnt + 4'h1;
    if (tick) s_nxt.sclk = ~s_r.sclk;
    if (falling) begin
      if (more) begin
        s_nxt.sh_d = {s_r.sh_d[14:0], 1'b0};
        s_nxt.sh_a = {s_r.sh_a[14:0], 1'b0};
        s_nxt.bitc = s_r.bitc + 5'h01;
        s_nxt.strobe = (s_r.bitc == SER_PRE_LAST); // strobe marks the last bit
      end else if (valid) begin
        s_nxt.sh_d = drv_word;
        s_nxt.sh_a = arr_word;
        s_nxt.bitc = 5'h00;
        s_nxt.busy = 1'b1;
        s_nxt.strobe = 1'b0;
      end else begin
        s_nxt.sh_d = 16'h0000;
        s_nxt.sh_a = 16'h0000;
        s_nxt.busy = 1'b0;
        s_nxt.strobe = 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) s_r <= R_RST;
    else s_r <= s_nxt;
  end
  assign drv_data = s_r.sh_d[15];
  assign arr_data = s_r.sh_a[15];
  assign drv_strobe = s_r.strobe;
  assign sclk = s_r.sclk;
  property p_ser_edge;
    @(posedge clk) disable iff (reset)
      ($changed(arr_data) || $changed(drv_data)) |-> $fell(sclk);
  endproperty
  a_ser_edge: assert property (p_ser_edge)
    else $error("serial data moved off the falling edge");
  property p_ser_strobe;
    @(posedge clk) disable iff (reset)
      $rose(drv_strobe) |=> drv_strobe [*3] ##1 !drv_strobe;
  endproperty
  a_ser_strobe: assert property (p_ser_strobe)
    else $error("strobe not one bit long");
  c_ser_word: cover property (@(posedge clk) disable iff (reset) $rose(drv_strobe));
endmodule
`default_nettype wire

// >>> tb/mao_array_model.sv
/*
  Far-side model of the mirror array and its reset driver: it records what
  the port presents on every data clock edge and every serial word.
  Assumes the port's output pins only; it drives nothing back.
*/
`timescale 1ns/10ps
`default_nettype none
module mao_array_model (
  // bit-plane pins
  input wire logic [14:0] lane,
  input wire logic dclk,
  input wire logic load_n,
  input wire logic sctrl,
  input wire logic trc,
  // serial bus pins
  input wire logic drv_data,
  input wire logic drv_strobe,
  input wire logic arr_data,
  input wire logic sclk
);
  logic [18:0] cap[$];
  logic [15:0] dsr = 16'h0000;
  logic [15:0] asr = 16'h0000;
  logic [15:0] drv_q[$];
  logic [15:0] arr_q[$];
  // take lanes and strobes on both clock edges; lanes move a cycle apart from the clock
  always @(dclk) begin
    cap.push_back({dclk, lane, load_n, sctrl, trc});
  end
  // shift both serial lines on the rising serial clock, close a word on the strobe
  always @(posedge sclk) begin
    dsr = {dsr[14:0], drv_data};
    asr = {asr[14:0], arr_data};
    if (drv_strobe) begin
      drv_q.push_back(dsr);
      arr_q.push_back(asr);
    end
  end
endmodule
`default_nettype wire

// >>> tb/mao_port_tb.sv
/*
  Self-checking bench for the mirror array output port.
  Assumes the design package and top; I2C is open drain with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module mao_port_tb;
  import mao_pkg::*;
  localparam logic [6:0] I2C_A = 7'h1B;
  logic clk, reset, plane_load, plane_sctrl, plane_trc, plane_valid;
  logic drv_enable, ser_valid, scl, sda_m;
  logic [14:0] plane_word;
  logic [15:0] ser_drv, ser_arr;
  mao_fmt_type array_fmt;
  logic [14:0] lane;
  logic dclk, load_n, sctrl_o, trc_o, ready, oen_n, ser_ready, dd, ds, ad, ac;
  logic sda_out, sda_oe, bus_swap;
  logic [7:0] d;
  logic a;
  int errors = 0;
  int check_count = 0;
  // open-drain wire: low when either side pulls
  wire logic sda;
  assign sda = sda_m & (~sda_oe | sda_out);

  mao_port #(.I2C_ADDR(I2C_A)) u_dut (.CLK(clk), .RESET(reset),
    .PLANE_WORD(plane_word), .PLANE_LOAD(plane_load), .PLANE_SCTRL(plane_sctrl),
    .PLANE_TRC(plane_trc), .PLANE_VALID(plane_valid), .PLANE_READY(ready),
    .ARRAY_FMT(array_fmt), .PLANE_DATA_LANE(lane), .PLANE_DATA_CLOCK(dclk),
    .PLANE_LOAD_N(load_n), .PLANE_SERIAL_CTRL(sctrl_o), .TOGGLE_RATE_CTRL(trc_o),
    .DRV_ENABLE(drv_enable), .RESET_DRIVER_OUT_EN_N(oen_n), .SER_VALID(ser_valid),
    .SER_READY(ser_ready), .SER_DRV_WORD(ser_drv), .SER_ARRAY_WORD(ser_arr),
    .RESET_DRIVER_BUS_DATA(dd), .RESET_DRIVER_BUS_STROBE(ds), .ARRAY_CTRL_BUS_DATA(ad),
    .ARRAY_CTRL_BUS_CLOCK(ac), .I2C_SCL(scl), .I2C_SDA_IN(sda), .I2C_SDA_OUT(sda_out),
    .I2C_SDA_OE(sda_oe), .BUS_SWAP(bus_swap));

  mao_array_model u_arr (.lane(lane), .dclk(dclk), .load_n(load_n), .sctrl(sctrl_o),
    .trc(trc_o), .drv_data(dd), .drv_strobe(ds), .arr_data(ad), .sclk(ac));

  task automatic tally_and_finish;
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [18:0] g, input logic [18:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one I2C bit, 400 ns period, sampled mid high phase
  task automatic i2c_bit(input logic b, output logic r);
    sda_m <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    @(negedge clk);
    r = sda;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic i2c_start;
    sda_m <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic i2c_stop;
    sda_m <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_m <= 1'b1;
    tick(4);
  endtask

  task automatic i2c_byte(input logic [7:0] b, input logic m, output logic [7:0] r,
                          output logic ak);
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
    i2c_bit(m, ak);
  endtask

  // write one register; ak is high if any byte went unacknowledged
  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] v,
                        output logic ak);
    logic [7:0] r;
    logic a0, a1, a2;
    i2c_start;
    i2c_byte({dev, 1'b0}, 1'b1, r, a0);
    i2c_byte(ra, 1'b1, r, a1);
    i2c_byte(v, 1'b1, r, a2);
    i2c_stop;
    ak = a0 | a1 | a2;
  endtask

  task automatic reg_rd(input logic [7:0] ra, output logic [7:0] v);
    logic [7:0] r;
    logic ak;
    i2c_start;
    i2c_byte({I2C_A, 1'b0}, 1'b1, r, ak);
    i2c_byte(ra, 1'b1, r, ak);
    i2c_start;
    i2c_byte({I2C_A, 1'b1}, 1'b1, r, ak);
    i2c_byte(8'hFF, 1'b1, v, ak);
    i2c_stop;
  endtask

  // expected lane pattern for a word under format and bit order
  function automatic logic [14:0] lmap(input logic [14:0] w, input logic f, input logic s);
    logic [14:0] v;
    logic [14:0] r;
    v = f ? (w & 15'h0FFF) : w;
    for (int i = 0; i < 15; i++) r[i] = v[14 - i];
    return s ? r : v;
  endfunction

  // three words back to back, then one idle slot, checked at the array's clock edges
  task automatic burst(input logic [14:0] w0, input logic f, input logic s);
    logic [14:0] w[3];
    int n0;
    int j;
    w[0] = w0;
    w[1] = ~w0;
    w[2] = w0 ^ 15'h2AD3;
    for (int i = 0; i < 3; i++) begin
      plane_word <= w[i];
      plane_load <= i[0];
      plane_sctrl <= ~i[0];
      plane_trc <= i[1];
      plane_valid <= 1'b1;
      @(negedge clk);
      for (int k = 0; k < 8 && ready !== 1'b1; k++) @(negedge clk);
      if (i == 0) n0 = u_arr.cap.size(); // next clock edge carries this word
      @(posedge clk);
    end
    plane_valid <= 1'b0;
    tick(6);
    for (int i = 0; i < 4; i++) begin
      j = (i < 3) ? i : 2;
      chk(u_arr.cap[n0 + i], {u_arr.cap[n0][18] ^ i[0], lmap(w[j], f, s), i == 3 || !i[0],
          i < 3 && !i[0], i < 3 && i[1]});
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #2000000;
    errors++;
    tally_and_finish;
  end

  initial begin
    reset = 1'b1;
    {plane_load, plane_sctrl, plane_trc, plane_valid, drv_enable, ser_valid} = '0;
    plane_word = '0;
    ser_drv = '0;
    ser_arr = '0;
    scl = 1'b1;
    sda_m = 1'b1;
    array_fmt = FMT_FULL;
    tick(2);
    reset <= 1'b0;
    @(negedge clk);
    chk({lane, load_n, oen_n, bus_swap, sda_oe}, {15'h0000, 4'hC});
    @(posedge clk);
    reg_rd(8'hA7, d);
    chk(d, 8'h00);
    reg_wr(7'h2A, 8'hA7, 8'h01, a);
    chk({a, bus_swap}, 2'h2);
    reg_rd(8'h10, d);
    chk(d, 8'h00);
    for (int s = 0; s < 2; s++) begin
      reg_wr(I2C_A, 8'hA7, s[0] ? 8'h01 : 8'hFE, a);
      reg_rd(8'hA7, d);
      chk({a, bus_swap, d}, {2'(s), 8'(s)});
      for (int f = 0; f < 2; f++) begin
        array_fmt <= mao_fmt_type'(f[0]);
        tick(1);
        burst(15'h5A3C, f[0], s[0]);
      end
    end
    drv_enable <= 1'b1;
    tick(1);
    @(negedge clk);
    chk(oen_n, 1'b0);
    @(posedge clk);
    drv_enable <= 1'b0;
    tick(1);
    @(negedge clk);
    chk(oen_n, 1'b1);
    @(posedge clk);
    begin
      int n;
      n = u_arr.drv_q.size();
      for (int i = 0; i < 2; i++) begin
        ser_drv <= i ? 16'h8001 : 16'hA5C3;
        ser_arr <= i ? 16'h7FFE : 16'h3C96;
        ser_valid <= 1'b1;
        @(negedge clk);
        for (int k = 0; k < 80 && ser_ready !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
      end
      ser_valid <= 1'b0;
      for (int k = 0; k < 200 && u_arr.drv_q.size() < n + 2; k++) tick(1);
      chk({u_arr.drv_q[n], u_arr.arr_q[n][2:0]}, {16'hA5C3, 3'h6});
      chk({u_arr.drv_q[n + 1], u_arr.arr_q[n + 1][15:13]}, {16'h8001, 3'h3});
      chk(u_arr.arr_q[n], 16'h3C96);
      chk(u_arr.arr_q[n + 1], 16'h7FFE);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
